/* core_irq_pkg.sv */
// constants, register map and types of the core interrupt controller
// assumes a 16-source request bus and a 16-bit program counter
package core_irq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_VEC = 16;
  localparam int IDX_W = 4;
  localparam int VEC_W = 5;
  localparam int PC_W = 16;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_CTRLA = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;
  localparam logic [1:0] IDX_LVL0PRI = 2'h2;
  localparam logic [1:0] IDX_HIGH_LEVEL_VECTOR = 2'h3;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_VBASE = 6;
  localparam int BIT_COMPACT = 5;
  localparam int BIT_ROTATE = 0;
  localparam int BIT_NMI_EX = 7;
  localparam int BIT_L1_EX = 1;
  localparam int BIT_L0_EX = 0;
  localparam logic [7:0] RST_CTRLA = 8'h00;
  localparam logic [7:0] RST_LVL0PRI = 8'h00;
  localparam logic [7:0] RST_HIGH_LEVEL_VECTOR = 8'h00;

  // ----------------------------------------------------------------
  // vector table
  // ----------------------------------------------------------------
  // which sources are non-maskable is fixed by the device
  localparam logic [N_VEC-1:0] NMI_MASK = 16'h0001;
  localparam logic [PC_W-1:0] RESET_ADDR = 16'h0000;
  localparam logic [PC_W-1:0] VEC_OFFSET = 16'h0000;
  localparam logic [PC_W-1:0] VEC_SIZE = 16'h0002;
  localparam logic [VEC_W-1:0] CVT_NMI_VEC = 5'h01;
  localparam logic [VEC_W-1:0] CVT_L1_VEC = 5'h02;
  localparam logic [VEC_W-1:0] CVT_L0_VEC = 5'h03;

  // ----------------------------------------------------------------
  // timing in core cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] PUSH_CYC = 2'h2;
  localparam logic [1:0] JUMP_CYC = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_JUMP} state_t;
  typedef enum logic [1:0] {LV_0, LV_1, LV_NMI} level_t;

endpackage

/* irq_cfg_if.sv */
// configuration and status carried between register file and sequencer
// assumes both ends share the single system clock
`timescale 1ns/1ns
interface irq_cfg_if;
  logic vbase_sel;
  logic compact_en;
  logic rotate_en;
  logic [7:0] lvl0pri;
  logic [7:0] high_level_vector;
  logic [7:0] status;
  logic l0_load;
  logic [core_irq_pkg::VEC_W-1:0] l0_vec;

  modport regs (output vbase_sel, compact_en, rotate_en, lvl0pri,
    high_level_vector, input status, l0_load, l0_vec);
  modport core (input vbase_sel, compact_en, rotate_en, lvl0pri,
    high_level_vector, output status, l0_load, l0_vec);
endinterface

/* irq_arbiter.sv */
// priority pick among request lines, fixed or rotating start
// assumes requests are already qualified by level
`timescale 1ns/1ns
module irq_arbiter (
  // requests and rotation
  input wire logic [core_irq_pkg::N_VEC-1:0] req,
  input wire logic rotate,
  input wire logic [core_irq_pkg::IDX_W-1:0] start,
  // result
  output logic found,
  output logic [core_irq_pkg::IDX_W-1:0] grant
);
  import core_irq_pkg::*;

  logic [N_VEC-1:0] rot;
  logic [IDX_W-1:0] base;

  assign base = rotate ? start : '0;

  // ----------------------------------------------------------------
  // rotate so that entry 0 is the highest priority
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N_VEC; g++) begin : g_rot
    assign rot[g] = req[IDX_W'(base + IDX_W'(g))];
  end

  // lowest rotated position wins, scanned from the top down
  always_comb begin
    found = 1'b0;
    grant = '0;
    for (int k = N_VEC - 1; k >= 0; k--) begin
      if (rot[k]) begin
        found = 1'b1;
        grant = IDX_W'(base + IDX_W'(k));
      end
    end
  end
endmodule

/* irq_regs.sv */
// avalon-mm register file of the interrupt controller
// assumes word-aligned byte addresses, one wait cycle per access
`timescale 1ns/1ns
module irq_regs (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [core_irq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // to the sequencer
  irq_cfg_if.regs cfg
);
  import core_irq_pkg::*;

  typedef struct packed {
    logic stall;
    logic [7:0] rdata;
    logic [7:0] ctrla;
    logic [7:0] lvl0pri;
    logic [7:0] high_level_vector;
  } regs_t;

  localparam regs_t RST_REGS = '{stall: 1'b1, rdata: 8'h00,
    ctrla: RST_CTRLA, lvl0pri: RST_LVL0PRI, high_level_vector: RST_HIGH_LEVEL_VECTOR};
  localparam logic [7:0] CTRLA_MASK = 8'h61;

  regs_t s_r;
  regs_t s_nxt;
  logic [1:0] idx;
  logic hit;
  logic [7:0] rd;

  assign idx = avs_address[3:2];
  // only word-aligned offsets are mapped
  assign hit = (avs_read | avs_write) & (avs_address[1:0] == 2'h0);

  // ----------------------------------------------------------------
  // read mux, unmapped and reserved bits read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd = 8'h00;
    if (hit) begin
      unique case (idx)
        IDX_CTRLA: rd = s_r.ctrla;
        IDX_STATUS: rd = cfg.status;
        IDX_LVL0PRI: rd = s_r.lvl0pri;
        IDX_HIGH_LEVEL_VECTOR: rd = s_r.high_level_vector;
      endcase
    end
  end

  // one wait cycle, write lands on the edge waitrequest is seen low
  always_comb begin
    s_nxt = s_r;
    s_nxt.stall = 1'b1;
    if ((avs_read | avs_write) && s_r.stall) begin
      s_nxt.stall = 1'b0;
      s_nxt.rdata = rd;
    end
    if (avs_write && !s_r.stall && hit && avs_byteenable[0]) begin
      unique case (idx)
        IDX_CTRLA: s_nxt.ctrla = avs_writedata[7:0] & CTRLA_MASK;
        IDX_STATUS: s_nxt.ctrla = s_r.ctrla; // read only
        IDX_LVL0PRI: s_nxt.lvl0pri = avs_writedata[7:0];
        IDX_HIGH_LEVEL_VECTOR: s_nxt.high_level_vector = avs_writedata[7:0];
      endcase
    end
    // hardware update wins over a software write in the same cycle
    if (cfg.l0_load) begin
      s_nxt.lvl0pri = {3'h0, cfg.l0_vec};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= RST_REGS;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = {24'h0, s_r.rdata};
  assign avs_waitrequest = s_r.stall;
  assign cfg.vbase_sel = s_r.ctrla[BIT_VBASE];
  assign cfg.compact_en = s_r.ctrla[BIT_COMPACT];
  assign cfg.rotate_en = s_r.ctrla[BIT_ROTATE];
  assign cfg.lvl0pri = s_r.lvl0pri;
  assign cfg.high_level_vector = s_r.high_level_vector;
endmodule

/* core_irq_controller.sv */
// two-level interrupt controller: arbitration, entry, return
// assumes the core pulses instr_done at each instruction boundary
// and handler_return when its handler return instruction retires
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns

// Summary of operation
// - enabled request vs running level decides ack now or pending.
// - acknowledge loads the program counter with the request's vector.
// - at least one instruction runs before any pending request is served.
// - status bits track executing levels; return restores prior state.
// - entry saves no status anywhere; only level bits change.
// - all maskable sources level 0 after reset; one chosen vector is level 1.
// - a level 1 request preempts a running level 0 handler.
// - fixed mode grants the lowest vector among level 0 requests.
// - rotating mode gives every level 0 source bounded service time.
// - maskable requests need global enable; acknowledge never alters it.
// - serving a request leaves the peripheral flag untouched.
// - reset address zero; vector base follows the base select bit.
// - request to vector takes finish cycle plus two push cycles.
// - jump from vector to handler takes three cycles.
// - multicycle instruction completes before entry starts.
// - runs on peripheral clock; stops while the debugger halts the core.
// - rotating mode makes the last level 0 vector lowest next time.
// - compact table: nmi vector 1, level 1 vector 2, level 0 vector 3.
// - nmi ignores global enable, is never preempted, lowest vector first.
module core_irq_controller (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm register slave
  input wire logic [core_irq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral request lines, one per vector, vector n on bit n-1
  input wire logic [core_irq_pkg::N_VEC-1:0] irq_req,
  // core handshake
  input wire logic global_ie,
  input wire logic instr_done,
  input wire logic handler_return,
  input wire logic debug_halt,
  input wire logic [core_irq_pkg::PC_W-1:0] app_start,
  // entry outputs
  output logic entry_busy,
  output logic pc_load,
  output logic [core_irq_pkg::PC_W-1:0] pc_vector,
  output logic irq_ack,
  output logic [core_irq_pkg::VEC_W-1:0] ack_vec
);
  import core_irq_pkg::*;

  typedef struct packed {
    state_t st;
    level_t lvl;
    logic [VEC_W-1:0] vec;
    logic [1:0] cnt;
    logic nmi_ex;
    logic l1_ex;
    logic l0_ex;
    logic need_instr;
    logic busy;
    logic pc_load;
    logic ack;
    logic [PC_W-1:0] pc;
  } seq_t;

  localparam seq_t RST_SEQ = '{st: ST_IDLE, lvl: LV_0, vec: '0,
    cnt: 2'h0, nmi_ex: 1'b0, l1_ex: 1'b0, l0_ex: 1'b0,
    need_instr: 1'b1, busy: 1'b0, pc_load: 1'b0, ack: 1'b0,
    pc: RESET_ADDR};

  seq_t s_r;
  seq_t s_nxt;

  irq_cfg_if cfg ();

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  irq_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg.regs)
  );

  // ----------------------------------------------------------------
  // request qualification by level
  // ----------------------------------------------------------------
  logic [N_VEC-1:0] nmi_req;
  logic [N_VEC-1:0] mask_req;
  logic [N_VEC-1:0] l1_sel;
  logic [N_VEC-1:0] l1_req;
  logic [N_VEC-1:0] l0_req;

  assign nmi_req = irq_req & NMI_MASK;
  assign mask_req = irq_req & ~NMI_MASK;

  // the chosen vector alone is promoted, all others stay level 0
  for (genvar g = 0; g < N_VEC; g++) begin : g_l1
    assign l1_sel[g] = (cfg.high_level_vector == 8'(g + 1));
  end
  assign l1_req = mask_req & l1_sel;
  assign l0_req = mask_req & ~l1_sel;

  // ----------------------------------------------------------------
  // arbiters
  // ----------------------------------------------------------------
  logic nmi_found;
  logic [IDX_W-1:0] nmi_idx;
  logic l1_found;
  logic [IDX_W-1:0] l1_idx;
  logic l0_found;
  logic [IDX_W-1:0] l0_idx;

  // nmi order is always static, lowest vector first
  irq_arbiter u_nmi_arb (
    .req(nmi_req),
    .rotate(1'b0),
    .start('0),
    .found(nmi_found),
    .grant(nmi_idx)
  );

  // at most one line is set here, the arbiter just encodes it
  irq_arbiter u_l1_arb (
    .req(l1_req),
    .rotate(1'b0),
    .start('0),
    .found(l1_found),
    .grant(l1_idx)
  );

  // stored vector number n starts the scan at index n, one past it
  irq_arbiter u_l0_arb (
    .req(l0_req),
    .rotate(cfg.rotate_en),
    .start(cfg.lvl0pri[IDX_W-1:0]),
    .found(l0_found),
    .grant(l0_idx)
  );

  // ----------------------------------------------------------------
  // eligibility against running handlers
  // ----------------------------------------------------------------
  logic take_nmi;
  logic take_l1;
  logic take_l0;
  logic start_ok;

  // nmi ignores the global enable and nothing preempts it
  assign take_nmi = nmi_found && !s_r.nmi_ex;
  // level 1 may cut into a level 0 handler
  assign take_l1 = global_ie && l1_found && !s_r.nmi_ex
    && !s_r.l1_ex;
  assign take_l0 = global_ie && l0_found && !s_r.nmi_ex
    && !s_r.l1_ex && !s_r.l0_ex;
  // entry only at a boundary, and never twice without an instruction
  assign start_ok = instr_done && !s_r.need_instr;

  // ----------------------------------------------------------------
  // vector address
  // ----------------------------------------------------------------
  logic [PC_W-1:0] vbase;
  logic [VEC_W-1:0] tab_vec;

  // reset address is fixed; only the table moves with the select bit
  assign vbase = cfg.vbase_sel ? VEC_OFFSET
    : PC_W'(app_start + VEC_OFFSET);

  // compact table folds every source of a level onto one slot
  always_comb begin
    tab_vec = s_r.vec;
    if (cfg.compact_en) begin
      unique case (s_r.lvl)
        LV_NMI: tab_vec = CVT_NMI_VEC;
        LV_1: tab_vec = CVT_L1_VEC;
        LV_0: tab_vec = CVT_L0_VEC;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // entry and return sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.ack = 1'b0;
    if (debug_halt) begin
      // frozen with the core; pulses drop so nothing repeats
      s_nxt.cnt = s_r.cnt;
    end else begin
      if (instr_done) begin
        s_nxt.need_instr = 1'b0;
      end
      unique case (s_r.st)
        ST_IDLE: begin
          if (start_ok && (take_nmi || take_l1 || take_l0)) begin
            s_nxt.st = ST_PUSH;
            s_nxt.busy = 1'b1;
            s_nxt.cnt = PUSH_CYC - 2'h1;
            if (take_nmi) begin
              s_nxt.lvl = LV_NMI;
              s_nxt.vec = VEC_W'(nmi_idx) + 5'h01;
            end else if (take_l1) begin
              s_nxt.lvl = LV_1;
              s_nxt.vec = VEC_W'(l1_idx) + 5'h01;
            end else begin
              s_nxt.lvl = LV_0;
              s_nxt.vec = VEC_W'(l0_idx) + 5'h01;
            end
          end
        end
        ST_PUSH: begin
          // two cycles for the return address to reach the stack
          s_nxt.cnt = s_r.cnt - 2'h1;
          if (s_r.cnt == 2'h0) begin
            s_nxt.st = ST_JUMP;
            s_nxt.cnt = JUMP_CYC - 2'h1;
            s_nxt.pc_load = 1'b1;
            s_nxt.ack = 1'b1;
            s_nxt.pc = PC_W'(vbase
              + PC_W'(PC_W'(tab_vec) * VEC_SIZE));
            s_nxt.need_instr = 1'b1;
            // only the level bits move, no status copy is kept
            unique case (s_r.lvl)
              LV_NMI: s_nxt.nmi_ex = 1'b1;
              LV_1: s_nxt.l1_ex = 1'b1;
              LV_0: s_nxt.l0_ex = 1'b1;
            endcase
          end
        end
        ST_JUMP: begin
          // vector slot jumps to the handler
          s_nxt.cnt = s_r.cnt - 2'h1;
          if (s_r.cnt == 2'h0) begin
            s_nxt.st = ST_IDLE;
            s_nxt.busy = 1'b0;
          end
        end
      endcase
      // nesting only climbs, so clearing the top bit undoes one entry
      if (handler_return) begin
        s_nxt.need_instr = 1'b1;
        if (s_r.nmi_ex) begin
          s_nxt.nmi_ex = 1'b0;
        end else if (s_r.l1_ex) begin
          s_nxt.l1_ex = 1'b0;
        end else if (s_r.l0_ex) begin
          // a stray return must not undo an entry landing this cycle
          s_nxt.l0_ex = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= RST_SEQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs and status
  // ----------------------------------------------------------------
  // no global-enable or flag-clear output exists: both stay with
  // the core and the peripheral
  assign entry_busy = s_r.busy;
  assign pc_load = s_r.pc_load;
  assign pc_vector = s_r.pc;
  assign irq_ack = s_r.ack;
  assign ack_vec = s_r.vec;
  assign cfg.status = {s_r.nmi_ex, 5'h00, s_r.l1_ex, s_r.l0_ex};
  // round-robin pointer follows every level 0 acknowledge
  assign cfg.l0_load = s_r.ack && (s_r.lvl == LV_0);
  assign cfg.l0_vec = s_r.vec;
endmodule

/* core_irq_checker_properties.sv */
// port-level checks of the core interrupt controller entry sequencer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module core_irq_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // core handshake
  input wire logic global_ie,
  input wire logic instr_done,
  input wire logic handler_return,
  input wire logic debug_halt,
  // entry outputs
  input wire logic entry_busy,
  input wire logic pc_load,
  input wire logic irq_ack,
  input wire logic [core_irq_pkg::VEC_W-1:0] ack_vec
);
  import core_irq_pkg::*;
  logic need_r;
  logic nmi_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // mirrors the one-instruction gate; frozen in halt like the sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      need_r <= 1'b1;
      nmi_r <= 1'b0;
    end else if (!debug_halt) begin
      need_r <= pc_load || handler_return || (need_r && !instr_done);
      if (irq_ack && ack_vec == 5'h01) begin
        nmi_r <= 1'b1;
      end else if (handler_return) begin
        nmi_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pulse_pair_a: assert property (pc_load == irq_ack)
    else $error("pc_load and irq_ack differ");
  entry_latency_a: assert property ($rose(entry_busy) |->
    !pc_load ##1 !pc_load ##1 pc_load)
    else $error("vector load not two cycles after entry start");
  entry_length_a: assert property ($rose(entry_busy) |->
    entry_busy [*5] ##1 !entry_busy)
    else $error("entry busy not five cycles");
  load_inside_a: assert property (pc_load |->
    entry_busy ##1 (entry_busy && !pc_load))
    else $error("vector load outside entry or not a pulse");
  instr_first_a: assert property ($rose(entry_busy) |->
    $past(instr_done) && !$past(need_r))
    else $error("entry without a finished instruction");
  global_mask_a: assert property (irq_ack && ack_vec != 5'h01 |->
    $past(global_ie, 3))
    else $error("maskable request taken while disabled");
  halt_freeze_a: assert property (debug_halt |=>
    $stable(entry_busy) && !pc_load)
    else $error("sequencer moved while halted");
  nmi_exclusive_a: assert property (nmi_r |-> !irq_ack)
    else $error("request taken inside nmi handler");
  ack_range_a: assert property (irq_ack |->
    ack_vec inside {[5'h01:5'h10]})
    else $error("acknowledged vector out of range");

  cover property (irq_ack && ack_vec == 5'h01);
  cover property (debug_halt && instr_done);
  cover property (handler_return ##[1:20] irq_ack);
endmodule

bind core_irq_controller core_irq_checker i_core_irq_checker (
  .clk(clk), .sys_rst(sys_rst), .global_ie(global_ie),
  .instr_done(instr_done), .handler_return(handler_return),
  .debug_halt(debug_halt), .entry_busy(entry_busy), .pc_load(pc_load),
  .irq_ack(irq_ack), .ack_vec(ack_vec));

/* core_model.sv */
// core-side partner: retires instructions, issues handler returns
// assumes the bench raises ret_go for one cycle per return
`timescale 1ns/1ns
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic [2:0] instr_len,
  input wire logic ret_go,
  // controller side
  input wire logic entry_busy,
  output logic instr_done,
  output logic handler_return
);
  logic [2:0] cnt_r;

  // ----------------------------------------------------------------
  // instruction retire
  // ----------------------------------------------------------------
  // a long instr_len stands for a multicycle instruction; retiring stops
  // one cycle after entry_busy rises and resumes instr_len+1 cycles after it falls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 3'h0;
      instr_done <= 1'b0;
      handler_return <= 1'b0;
    end else begin
      handler_return <= ret_go && !handler_return;
      instr_done <= !entry_busy && cnt_r >= instr_len;
      cnt_r <= (entry_busy || cnt_r >= instr_len) ? 3'h0 : cnt_r + 3'h1;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench of the core interrupt controller
// assumes the core partner model and the bound port checker
`timescale 1ns/1ns
module testbench;
  import core_irq_pkg::*;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, rng_r;
  logic [15:0] irq_req, app_start, pc_vector;
  logic global_ie, instr_done, handler_return, debug_halt, ret_go;
  logic entry_busy, pc_load, irq_ack;
  logic [4:0] ack_vec;
  logic [2:0] instr_len;
  int mismatches, compares, acks, ctrl, lvl1, last0, ex, i;

  core_irq_controller i_core_irq_controller (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req), .global_ie(global_ie), .instr_done(instr_done),
    .handler_return(handler_return), .debug_halt(debug_halt),
    .app_start(app_start), .entry_busy(entry_busy), .pc_load(pc_load),
    .pc_vector(pc_vector), .irq_ack(irq_ack), .ack_vec(ack_vec));
  core_model i_core_model (.clk(clk), .sys_rst(sys_rst),
    .instr_len(instr_len), .ret_go(ret_go), .entry_busy(entry_busy),
    .instr_done(instr_done), .handler_return(handler_return));

  // ----------------------------------------------------------------
  // clock, counters and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (irq_ack === 1'b1) acks++;

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail();
    mismatches++;
    report_and_stop();
  endtask
  task automatic check(input string s, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done, mismatches %0d", s, mismatches);
  endtask
  function automatic logic [31:0] rnd();
    rng_r ^= rng_r << 13;
    rng_r ^= rng_r >> 17;
    rng_r ^= rng_r << 5;
    return rng_r;
  endfunction
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic [3:0] a, input logic w,
    input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) fail();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
    if (a == 4'h0) ctrl = d & 8'h61;
    if (a == 4'hc) lvl1 = d;
  endtask
  task automatic rd_chk(input string s, input logic [3:0] a,
    input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    check(s, q, e);
  endtask
  task automatic drive(input logic [15:0] r);
    @(posedge clk);
    irq_req <= r;
  endtask
  task automatic quiet(input int n, input string s);
    int a0;
    a0 = acks;
    repeat (n) @(posedge clk);
    check(s, acks - a0, 0);
  endtask

  // ----------------------------------------------------------------
  // reference model of arbitration and vector placement
  // ----------------------------------------------------------------
  function automatic int pick(input logic [15:0] r);
    int b;
    if (r[0] && !ex[7]) return 1;
    if (global_ie !== 1'b1) return 0;
    if (lvl1 > 1 && lvl1 <= 16 && r[lvl1-1] && ex[7:1] == 0) return lvl1;
    if (ex != 0) return 0;
    for (int k = 0; k < 16; k++) begin
      b = ctrl[0] ? (last0 + k) % 16 : k;
      if (r[b] && b != 0 && b + 1 != lvl1) return b + 1;
    end
    return 0;
  endfunction
  // the flag stays up: the request line is held until the bench drops it
  task automatic take(input logic [15:0] r);
    int v, n, lv, b, e;
    drive(r);
    v = pick(r);
    n = 0;
    while (irq_ack !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) fail();
    lv = (v == 1) ? 7 : (v == lvl1) ? 1 : 0;
    e = ctrl[5] ? ((lv == 7) ? 1 : (lv == 1) ? 2 : 3) : v;
    b = ctrl[6] ? 0 : app_start;
    check("ack_vec", ack_vec, v);
    check("pc_vector", pc_vector, (b + 2 * e) & 16'hffff);
    ex[lv] = 1;
    if (lv == 0) last0 = v;
    rd_chk("status", 4'h4, ex);
  endtask
  task automatic ret();
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    repeat (2) @(posedge clk);
    if (ex[7]) ex[7] = 0;
    else if (ex[1]) ex[1] = 0;
    else ex[0] = 0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rng_r = 32'h41d77d28;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    irq_req = 16'h0000;
    global_ie = 1'b0;
    debug_halt = 1'b0;
    ret_go = 1'b0;
    instr_len = 3'h0;
    app_start = 16'(rnd());
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("ctrla", 4'h0, 0);
    rd_chk("lvl0pri", 4'h8, 0);
    rd_chk("high_level_vector", 4'hc, 0);
    rd_chk("status", 4'h4, 0);
    wr(4'h4, 8'h83);
    rd_chk("status ro", 4'h4, 0);
    rd_chk("unmapped", 4'h2, 0);
    check("pc_vector", pc_vector, 0);
    wr(4'h0, 8'hff);
    rd_chk("ctrla", 4'h0, 32'h61);
    wr(4'h0, 8'h00);
    endt("registers");
    // halt the core, then request and enable globally on the next edge
    debug_halt <= 1'b1;
    drive(16'h0008);
    global_ie <= 1'b1;
    quiet(30, "halted acks");
    global_ie <= 1'b0;
    debug_halt <= 1'b0;
    quiet(30, "masked acks");
    take(16'h0001);
    @(posedge clk);
    global_ie <= 1'b1;
    drive(16'h0008);
    quiet(30, "nmi preempt");
    ret();
    take(16'h0008);
    rd_chk("lvl0pri", 4'h8, 4);
    wr(4'hc, 8'h09);
    take(16'h0108);
    drive(16'h0008);
    ret();
    rd_chk("status", 4'h4, ex);
    ret();
    take(16'h0008);
    drive(16'h0000);
    ret();
    endt("levels");
    take(16'h0054);
    ret();
    take(16'h0054);
    wr(4'h0, 8'h01);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      instr_len <= 3'(rnd() % 4);
      ret();
      take(16'h0054);
    end
    rd_chk("lvl0pri", 4'h8, last0);
    drive(16'h0000);
    ret();
    endt("arbitration");
    wr(4'h0, 8'h60);
    take(16'h0101);
    drive(16'h0100);
    ret();
    take(16'h0100);
    drive(16'h0000);
    ret();
    take(16'h0008);
    drive(16'h0000);
    ret();
    endt("compact");
    report_and_stop();
  end
endmodule
